// ===== tb_tiny_mcu_exec_subset.sv
// Self-checking bench for the execution subset core and its fabric model.
// Assumes tmx_exec, tmx_fabric and the bound checker in the same build.
`timescale 1ns/100ps
`default_nettype none
`include "tmx_defines.vh"

module tb_tiny_mcu_exec_subset;
    logic       ref_clk, srst, bus_wr, bus_rd, op_valid, op_use_literal, irq_pin;
    logic       op_ready, carry_flag, zero_flag, int_enable, mc, mz, mie, tk;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, op_literal, port_identifier;
    logic [7:0] out_port, capture_ff, rm [16];
    logic [4:0] op_code;
    logic [3:0] op_first_sel, op_second_sel;
    logic [9:0] pc_value, stack_top_address, mpc, p, q;
    int         n_fail, checked, cyc, msp, w;

    tmx_exec u_dut (.*);
    tmx_fabric u_fab (.*);

    // Clock of 4 ns
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Cut a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_fail++;
            close_out();
        end
    end

    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [9:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic bw(input logic [7:0] a, d);
        @(posedge ref_clk);
        {bus_wr, bus_addr, bus_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic br(input logic [7:0] a, e);
        @(posedge ref_clk);
        {bus_rd, bus_addr} <= {1'b1, a};
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1 chk(bus_rdata, e);
    endtask

    // Expected {carry, zero, result}; d[8] is the carry out
    function automatic logic [9:0] alu(input logic [4:0] c, input logic [7:0] x, y,
                                       input logic ci, zi);
        logic [8:0] d;
        d = 9'h000;
        case (c)
            `TMX_OP_OR:         d[7:0] = x | y;
            `TMX_OP_XOR:        d[7:0] = x ^ y;
            `TMX_OP_ROT_L:      d = {x, x[7]};
            `TMX_OP_ROT_R:      d = {x[0], x[0], x[7:1]};
            `TMX_OP_SHL_ZERO:   d = {x, 1'b0};
            `TMX_OP_SHL_ONE:    d = {x, 1'b1};
            `TMX_OP_SHL_CARRY:  d = {x, ci};
            `TMX_OP_SHL_EXT:    d = {x, x[0]};
            `TMX_OP_SHR_ZERO:   d = {x[0], 1'b0, x[7:1]};
            `TMX_OP_SHR_ONE:    d = {x[0], 1'b1, x[7:1]};
            `TMX_OP_SHR_CARRY:  d = {x[0], ci, x[7:1]};
            `TMX_OP_SHR_ARITH:  d = {x[0], x[7], x[7:1]};
            `TMX_OP_SUB:        d = {1'b0, x} - {1'b0, y};
            `TMX_OP_SUB_BORROW: d = {1'b0, x} - {1'b0, y} - {8'h00, ci};
            `TMX_OP_TEST:       return {^(x & y), (x & y) == 8'h00, x};
            default:            return {ci, zi, x};
        endcase
        return {d[8], d[7:0] == 8'h00 && c != `TMX_OP_SHL_ONE && c != `TMX_OP_SHR_ONE, d[7:0]};
    endfunction

    task automatic op(input logic [4:0] c, input logic [3:0] a, b, input logic u,
                      input logic [7:0] k, input logic [9:0] npc);
        logic [7:0] y;
        logic [9:0] e;
        y = u ? k : rm[b];
        e = alu(c, rm[a], y, mc, mz);
        @(posedge ref_clk);
        {op_valid, op_code, op_first_sel, op_second_sel, op_use_literal, op_literal} <=
            {1'b1, c, a, b, u, k};
        @(posedge ref_clk);
        op_valid <= 1'b0;
        {rm[a], mc, mz, mpc} = {e[7:0], e[9], e[8], npc};
        #1 chk(carry_flag, mc);
        chk(zero_flag, mz);
        chk(pc_value, mpc);
        chk(int_enable, mie);
        br({4'h0, a}, rm[a]);
        if (c == `TMX_OP_OUT) begin
            chk(port_identifier, y);
            chk(out_port, rm[a]);
            if (y == 8'hff) chk(capture_ff, rm[a]);
        end
        if (c == `TMX_OP_STORE) br({2'b01, y[5:0]}, rm[a]);
    endtask

    // Main sequence
    initial begin
        {srst, bus_wr, bus_rd, op_valid, irq_pin, op_use_literal} = 6'h20;
        {bus_addr, bus_wdata, op_literal, op_code, op_first_sel, op_second_sel} = '0;
        {mc, mz, mie, mpc, msp} = '0;
        void'($urandom(63169));
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            rm[i] = i == 0 ? 8'h00 : i == 15 ? 8'hff : 8'($urandom);
            bw(8'(i), rm[i]);
        end
        op(`TMX_OP_XOR, 4'h3, 4'h3, 1'b0, 8'h00, mpc + 10'h001);
        op(`TMX_OP_SUB, 4'h0, 4'hf, 1'b0, 8'h00, mpc + 10'h001);
        op(`TMX_OP_OUT, 4'h5, 4'h0, 1'b1, 8'hff, mpc + 10'h001);
        for (int i = 0; i < 300; i++) begin
            w = i < 17 ? i : $urandom_range(16, 0);
            op(5'(w < 3 ? w + 1 : w + 8), 4'($urandom), 4'($urandom), 1'($urandom),
               8'($urandom), mpc + 10'h001);
        end
        // Plain and each conditional return under random flags
        for (int j = 0; j < 15; j++) begin
            {p, q, mc, mz} = 22'($urandom);
            tk = j % 5 == 0 || (j % 5 == 1 && mc) || (j % 5 == 2 && !mc) ||
                 (j % 5 == 3 && mz) || (j % 5 == 4 && !mz);
            bw(`TMX_ADDR_PC_LO, p[7:0]);
            bw(`TMX_ADDR_PC_HI, {6'h00, p[9:8]});
            bw(`TMX_ADDR_PUSH, 8'h00);
            bw(`TMX_ADDR_PC_LO, q[7:0]);
            bw(`TMX_ADDR_PC_HI, {6'h00, q[9:8]});
            bw(`TMX_ADDR_FLAGS, {6'h00, mc, mz});
            op(5'(`TMX_OP_RET + j % 5), 4'h0, 4'h0, 1'b0, 8'h00,
               tk ? p + 10'h001 : q + 10'h001);
            msp = tk ? msp : msp + 1;
            br(`TMX_ADDR_SP, 8'(msp));
        end
        // Interrupt entry, flags trashed, then each interrupt return
        for (int v = 0; v < 2; v++) begin
            {mie, mc, mz} = v ? 3'b110 : 3'b101;
            bw(`TMX_ADDR_FLAGS, {5'h00, mie, mc, mz});
            irq_pin <= 1'b1;
            for (w = 0; w < 20 && pc_value !== `TMX_INT_VECTOR; w++) @(posedge ref_clk) #1;
            @(posedge ref_clk);
            irq_pin <= 1'b0;
            chk(pc_value, `TMX_INT_VECTOR);
            chk(int_enable, 1'b0);
            bw(`TMX_ADDR_FLAGS, 8'h00);
            repeat (6) @(posedge ref_clk);
            mie = 1'(v);
            op(v ? `TMX_OP_RETI_EN : `TMX_OP_RETI_DIS, 4'h0, 4'h0, 1'b0, 8'h00, mpc);
        end
        br(8'h20, 8'h00);
        // Mid-run reset clears core state and the output port
        @(posedge ref_clk) srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        #1 chk(pc_value, 10'h000);
        chk({carry_flag, zero_flag, int_enable}, 3'h0);
        chk(port_identifier, 8'h00);
        chk(out_port, 8'h00);
        br(`TMX_ADDR_SP, 8'h00);
        br(8'h05, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire

// ===== tmx_defines.vh
// Constants for the execution subset of the small 8-bit controller core.
// Assumes it is included by bare name from tmx_exec.v, the bench and the checker.
//
// Function
// [RULE1] Sixteen 8-bit registers, any operand selectable
// [RULE2] OR into first register, zero set, carry cleared
// [RULE3] XOR into first register, zero set, carry cleared
// [RULE4] Indirect port write, flags untouched
// [RULE5] Direct port write uses 8-bit literal address
// [RULE6] Return loads stack top plus one
// [RULE7] Conditional returns only when condition holds
// [RULE8] Interrupt return restores flags, sets enable; the code clears enable for the disable variant
// [RULE9] Rotate left, carry from old bit seven
// [RULE10] Rotate right, carry from old bit zero
// [RULE11] Left shift zero fill, carry bit seven
// [RULE12] Left shift one fill, zero flag cleared
// [RULE13] Left shift inserts old carry at bit zero
// [RULE14] Left shift keeps old bit zero
// [RULE15] Right shift zero fill, carry bit zero
// [RULE16] Right shift one fill, zero flag cleared
// [RULE17] Right shift inserts old carry at bit seven
// [RULE18] Arithmetic right shift keeps bit seven
// [RULE19] Store first register at 6-bit scratchpad address
// [RULE20] Subtract updates zero and carry
// [RULE21] Subtract with borrow uses carry as borrow
// [RULE22] Bit test sets zero and odd parity carry
// [RULE23] Interrupt preserves flags, pushes, jumps to vector
// [RULE24] False conditional return continues sequentially
// [RULE25] Register bit test parity uses second register
`ifndef TMX_DEFINES_VH
`define TMX_DEFINES_VH

// ****************************************************************
// Operation codes
// ****************************************************************
`define TMX_OP_NOP        5'h00
`define TMX_OP_OR         5'h01
`define TMX_OP_XOR        5'h02
`define TMX_OP_OUT        5'h03
`define TMX_OP_RET        5'h04
`define TMX_OP_RET_C      5'h05
`define TMX_OP_RET_NC     5'h06
`define TMX_OP_RET_Z      5'h07
`define TMX_OP_RET_NZ     5'h08
`define TMX_OP_RETI_DIS   5'h09
`define TMX_OP_RETI_EN    5'h0a
`define TMX_OP_ROT_L      5'h0b
`define TMX_OP_ROT_R      5'h0c
`define TMX_OP_SHL_ZERO   5'h0d
`define TMX_OP_SHL_ONE    5'h0e
`define TMX_OP_SHL_CARRY  5'h0f
`define TMX_OP_SHL_EXT    5'h10
`define TMX_OP_SHR_ZERO   5'h11
`define TMX_OP_SHR_ONE    5'h12
`define TMX_OP_SHR_CARRY  5'h13
`define TMX_OP_SHR_ARITH  5'h14
`define TMX_OP_STORE      5'h15
`define TMX_OP_SUB        5'h16
`define TMX_OP_SUB_BORROW 5'h17
`define TMX_OP_TEST       5'h18

// ****************************************************************
// Register bus map
// ****************************************************************
`define TMX_ADDR_REG_BASE  8'h00
`define TMX_ADDR_FLAGS     8'h10
`define TMX_ADDR_PC_LO     8'h11
`define TMX_ADDR_PC_HI     8'h12
`define TMX_ADDR_PUSH      8'h13
`define TMX_ADDR_STACK_TOP 8'h14
`define TMX_ADDR_SP        8'h15
`define TMX_ADDR_PAD_BASE  8'h40

// Flag register fields
`define TMX_FLAG_ZERO  0
`define TMX_FLAG_CARRY 1
`define TMX_FLAG_IE    2

// ****************************************************************
// Sizes and fixed values
// ****************************************************************
`define TMX_INT_VECTOR  10'h3ff
`define TMX_STACK_DEPTH 31
`define TMX_PAD_DEPTH   64
`define TMX_NUM_REGS    16

`endif

// ===== tmx_exec.v
// Execution datapath for logic, shift, subtract, test, store, output
// and return operations of a small 8-bit controller core.
// Assumes a sequencer drives one operation per cycle on the op port,
// and fabric logic samples port_identifier and out_port.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tmx_defines.vh"

module tmx_exec #(
    parameter STACK_DEPTH = `TMX_STACK_DEPTH,
    parameter PAD_DEPTH   = `TMX_PAD_DEPTH
) (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       srst,
    // Register bus
    input  wire [7:0] bus_addr,
    input  wire [7:0] bus_wdata,
    input  wire       bus_wr,
    input  wire       bus_rd,
    output reg  [7:0] bus_rdata,
    // Operation port
    input  wire       op_valid,
    input  wire [4:0] op_code,
    input  wire [3:0] op_first_sel,
    input  wire [3:0] op_second_sel,
    input  wire       op_use_literal,
    input  wire [7:0] op_literal,
    output wire       op_ready,
    // Interrupt pin
    input  wire       irq_pin,
    // Output port toward fabric
    output reg  [7:0] port_identifier,
    output reg  [7:0] out_port,
    // Core state
    output reg  [9:0] pc_value,
    output reg        carry_flag,
    output reg        zero_flag,
    output reg        int_enable,
    output wire [9:0] stack_top_address
);

    // ****************************************************************
    // State
    // ****************************************************************
    reg  [7:0] regs_ff [0:`TMX_NUM_REGS-1];
    reg  [7:0] pad_ff  [0:PAD_DEPTH-1];
    reg  [9:0] stack_ff [0:STACK_DEPTH-1];
    reg  [4:0] sp_ff;
    reg        keep_zero_ff;
    reg        keep_carry_ff;
    reg        irq_s1_ff;
    reg        irq_s2_ff;
    reg        irq_s3_ff;
    reg        irq_lvl_ff;

    // ****************************************************************
    // Interrupt pin synchroniser
    // ****************************************************************
    // Level accepted only once second and third stage agree
    always @(posedge ref_clk) begin
        if (srst) begin
            irq_s1_ff  <= 1'b0;
            irq_s2_ff  <= 1'b0;
            irq_s3_ff  <= 1'b0;
            irq_lvl_ff <= 1'b0;
        end else begin
            irq_s1_ff <= irq_pin;
            irq_s2_ff <= irq_s1_ff;
            irq_s3_ff <= irq_s2_ff;
            if (irq_s2_ff == irq_s3_ff) begin
                irq_lvl_ff <= irq_s3_ff;
            end
        end
    end

    wire irq_take = irq_lvl_ff & int_enable;
    // Operations stall while an interrupt is being entered
    assign op_ready = ~irq_take;
    wire op_go = op_valid & ~irq_take;

    // ****************************************************************
    // Operand fetch
    // ****************************************************************
    // [RULE1] Any register selectable
    wire [7:0] opa = regs_ff[op_first_sel];
    wire [7:0] reg_b = regs_ff[op_second_sel];
    wire [7:0] opb = op_use_literal ? op_literal : reg_b;

    // Stack pointer neighbours with wrap
    wire [4:0] sp_dec = (sp_ff == 5'h00) ? STACK_DEPTH[4:0] - 5'h01
                                         : sp_ff - 5'h01;
    wire [4:0] sp_inc = (sp_ff == STACK_DEPTH[4:0] - 5'h01) ? 5'h00
                                                          : sp_ff + 5'h01;
    assign stack_top_address = stack_ff[sp_dec];
    wire [9:0] pc_inc = pc_value + 10'h001;
    wire [9:0] tos_inc = stack_top_address + 10'h001;

    // ****************************************************************
    // Result and flag computation
    // ****************************************************************
    reg  [7:0] nxt_res;
    reg        nxt_carry;
    reg        nxt_zero;
    reg        res_wr;
    reg        flag_wr;
    reg        do_pop;
    reg  [9:0] nxt_pc;
    reg  [8:0] diff;
    wire [7:0] and_res = opa & reg_b;
    wire [7:0] test_and = op_use_literal ? (opa & op_literal) : and_res;
    // [RULE7] Condition of each conditional return
    wire       ret_hit  = (op_code == `TMX_OP_RET_C)  ?  carry_flag :
                          (op_code == `TMX_OP_RET_NC) ? ~carry_flag :
                          (op_code == `TMX_OP_RET_Z)  ?  zero_flag  : ~zero_flag;

    always @* begin
        nxt_res   = opa;
        nxt_carry = carry_flag;
        nxt_zero  = zero_flag;
        res_wr    = 1'b0;
        flag_wr   = 1'b0;
        do_pop    = 1'b0;
        nxt_pc    = pc_inc;
        diff      = 9'h000;
        case (op_code)
            // [RULE2] OR with clear carry
            `TMX_OP_OR: begin
                nxt_res   = opa | opb;
                nxt_carry = 1'b0;
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE3] XOR with clear carry
            `TMX_OP_XOR: begin
                nxt_res   = opa ^ opb;
                nxt_carry = 1'b0;
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE6] Plain return
            `TMX_OP_RET: begin
                nxt_pc = tos_inc;
                do_pop = 1'b1;
            end
            // [RULE7] Conditional returns
            `TMX_OP_RET_C, `TMX_OP_RET_NC, `TMX_OP_RET_Z, `TMX_OP_RET_NZ: begin
                // [RULE24] Else continue
                nxt_pc = ret_hit ? tos_inc : pc_inc;
                do_pop = ret_hit;
            end
            // [RULE8] Interrupt return to stack top
            `TMX_OP_RETI_DIS, `TMX_OP_RETI_EN: begin
                nxt_pc    = stack_top_address;
                do_pop    = 1'b1;
                nxt_carry = keep_carry_ff;
                nxt_zero  = keep_zero_ff;
                flag_wr   = 1'b1;
            end
            // [RULE9] Rotate left
            `TMX_OP_ROT_L: begin
                nxt_res   = {opa[6:0], opa[7]};
                nxt_carry = opa[7];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE10] Rotate right
            `TMX_OP_ROT_R: begin
                nxt_res   = {opa[0], opa[7:1]};
                nxt_carry = opa[0];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE11] Left zero fill
            `TMX_OP_SHL_ZERO: begin
                nxt_res   = {opa[6:0], 1'b0};
                nxt_carry = opa[7];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE12] Left one fill
            `TMX_OP_SHL_ONE: begin
                nxt_res   = {opa[6:0], 1'b1};
                nxt_carry = opa[7];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE13] Left through carry
            `TMX_OP_SHL_CARRY: begin
                nxt_res   = {opa[6:0], carry_flag};
                nxt_carry = opa[7];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE14] Left keep bit zero
            `TMX_OP_SHL_EXT: begin
                nxt_res   = {opa[6:0], opa[0]};
                nxt_carry = opa[7];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE15] Right zero fill
            `TMX_OP_SHR_ZERO: begin
                nxt_res   = {1'b0, opa[7:1]};
                nxt_carry = opa[0];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE16] Right one fill
            `TMX_OP_SHR_ONE: begin
                nxt_res   = {1'b1, opa[7:1]};
                nxt_carry = opa[0];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE17] Right through carry
            `TMX_OP_SHR_CARRY: begin
                nxt_res   = {carry_flag, opa[7:1]};
                nxt_carry = opa[0];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE18] Sign extending right
            `TMX_OP_SHR_ARITH: begin
                nxt_res   = {opa[7], opa[7:1]};
                nxt_carry = opa[0];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE20] Plain subtract, carry is borrow
            `TMX_OP_SUB: begin
                diff      = {1'b0, opa} - {1'b0, opb};
                nxt_res   = diff[7:0];
                nxt_carry = diff[8];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE21] Subtract with borrow
            `TMX_OP_SUB_BORROW: begin
                diff      = {1'b0, opa} - {1'b0, opb} - {8'h00, carry_flag};
                nxt_res   = diff[7:0];
                nxt_carry = diff[8];
                res_wr    = 1'b1;
                flag_wr   = 1'b1;
            end
            // [RULE22] Test without register write
            `TMX_OP_TEST: begin
                nxt_zero  = (test_and == 8'h00);
                // [RULE25] Parity over first and second register, or over first register and literal when op_use_literal is set
                nxt_carry = ^test_and;
                flag_wr   = 1'b1;
            end
            default: nxt_pc = pc_inc;
        endcase
        // Zero flag from result for writing operations
        if (res_wr) begin
            nxt_zero = (nxt_res == 8'h00);
        end
        // [RULE12] Zero forced clear
        // [RULE16] Zero forced clear
        if (op_code == `TMX_OP_SHL_ONE || op_code == `TMX_OP_SHR_ONE) begin
            nxt_zero = 1'b0;
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    // Bus write first, operation result overrides on the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `TMX_NUM_REGS; gi = gi + 1) begin : g_reg
            always @(posedge ref_clk) begin
                if (srst) begin
                    regs_ff[gi] <= 8'h00;
                end else begin
                    if (bus_wr && bus_addr == (`TMX_ADDR_REG_BASE + gi)) begin
                        regs_ff[gi] <= bus_wdata;
                    end
                    if (op_go && res_wr && op_first_sel == gi) begin
                        regs_ff[gi] <= nxt_res;
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Scratchpad
    // ****************************************************************
    // [RULE19] Store at 6-bit address
    always @(posedge ref_clk) begin
        if (op_go && op_code == `TMX_OP_STORE) begin
            pad_ff[opb[5:0]] <= opa;
        end
    end

    // ****************************************************************
    // Output port
    // ****************************************************************
    always @(posedge ref_clk) begin
        if (srst) begin
            port_identifier <= 8'h00;
            out_port        <= 8'h00;
        end else if (op_go && op_code == `TMX_OP_OUT) begin
            // [RULE4] Id from second operand
            // [RULE5] Literal gives 8-bit port
            port_identifier <= opb;
            out_port        <= opa;
        end
    end

    // ****************************************************************
    // Program counter, stack, flags, interrupt enable
    // ****************************************************************
    always @(posedge ref_clk) begin
        if (srst) begin
            pc_value      <= 10'h000;
            sp_ff         <= 5'h00;
            carry_flag    <= 1'b0;
            zero_flag     <= 1'b0;
            int_enable    <= 1'b0;
            keep_carry_ff <= 1'b0;
            keep_zero_ff  <= 1'b0;
        end else if (irq_take) begin
            // [RULE23] Preserve, disable, push, vector
            keep_carry_ff   <= carry_flag;
            keep_zero_ff    <= zero_flag;
            int_enable      <= 1'b0;
            stack_ff[sp_ff] <= pc_value;
            sp_ff           <= sp_inc;
            pc_value        <= `TMX_INT_VECTOR;
        end else begin
            if (bus_wr) begin
                case (bus_addr)
                    `TMX_ADDR_FLAGS: begin
                        zero_flag  <= bus_wdata[`TMX_FLAG_ZERO];
                        carry_flag <= bus_wdata[`TMX_FLAG_CARRY];
                        int_enable <= bus_wdata[`TMX_FLAG_IE];
                    end
                    `TMX_ADDR_PC_LO: begin
                        pc_value[7:0] <= bus_wdata;
                    end
                    `TMX_ADDR_PC_HI: begin
                        pc_value[9:8] <= bus_wdata[1:0];
                    end
                    `TMX_ADDR_PUSH: begin
                        stack_ff[sp_ff] <= pc_value;
                        sp_ff           <= sp_inc;
                    end
                    default: sp_ff <= sp_ff;
                endcase
            end
            if (op_go) begin
                pc_value <= nxt_pc;
                if (do_pop) begin
                    sp_ff <= sp_dec;
                end
                if (flag_wr) begin
                    carry_flag <= nxt_carry;
                    zero_flag  <= nxt_zero;
                end
                // [RULE8] Enable per variant
                if (op_code == `TMX_OP_RETI_DIS) begin
                    int_enable <= 1'b0;
                end else if (op_code == `TMX_OP_RETI_EN) begin
                    int_enable <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Register bus read
    // ****************************************************************
    // Data stands one cycle after the read strobe only
    always @(posedge ref_clk) begin
        if (srst || !bus_rd) begin
            bus_rdata <= 8'h00;
        end else if (bus_addr < `TMX_NUM_REGS) begin
            bus_rdata <= regs_ff[bus_addr[3:0]];
        end else if (bus_addr >= `TMX_ADDR_PAD_BASE
                     && bus_addr < `TMX_ADDR_PAD_BASE + PAD_DEPTH) begin
            bus_rdata <= pad_ff[bus_addr[5:0]];
        end else begin
            case (bus_addr)
                `TMX_ADDR_FLAGS:     bus_rdata <= {5'h00, int_enable,
                                                   carry_flag, zero_flag};
                `TMX_ADDR_PC_LO:     bus_rdata <= pc_value[7:0];
                `TMX_ADDR_PC_HI:     bus_rdata <= {6'h00, pc_value[9:8]};
                `TMX_ADDR_STACK_TOP: bus_rdata <= stack_top_address[7:0];
                `TMX_ADDR_SP:        bus_rdata <= {3'h0, sp_ff};
                default:             bus_rdata <= 8'h00;
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== tmx_exec_asserts.sv
// Port-level checks for the execution subset core.
// Assumes binding to tmx_exec, one clock, reset srst.
`timescale 1ns/100ps
`default_nettype none
`include "tmx_defines.vh"

module tmx_exec_chk (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       srst,
    // Requests
    input wire logic       bus_wr,
    input wire logic       op_valid,
    input wire logic [4:0] op_code,
    input wire logic       op_use_literal,
    input wire logic [7:0] op_literal,
    input wire logic       op_ready,
    // Results
    input wire logic [7:0] port_identifier,
    input wire logic [9:0] pc_value,
    input wire logic       carry_flag,
    input wire logic       zero_flag,
    input wire logic       int_enable,
    input wire logic [9:0] stack_top_address
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Operation accepted this cycle
    wire acc = op_valid && op_ready;

    a_or_carry: assert property (acc && op_code == `TMX_OP_OR |=> !carry_flag)
        else $error("or left carry set");
    a_xor_carry: assert property (acc && op_code == `TMX_OP_XOR |=> !carry_flag)
        else $error("xor left carry set");
    a_fill_zero: assert property (acc && (op_code == `TMX_OP_SHL_ONE ||
        op_code == `TMX_OP_SHR_ONE) |=> !zero_flag) else $error("one fill left zero set");
    a_out_flags: assert property (acc && op_code == `TMX_OP_OUT && !bus_wr
        |=> $stable(carry_flag) && $stable(zero_flag)) else $error("output changed flags");
    a_out_direct: assert property (acc && op_code == `TMX_OP_OUT && op_use_literal
        |=> port_identifier == $past(op_literal)) else $error("wrong direct port");
    a_ret_target: assert property (acc && op_code == `TMX_OP_RET
        |=> pc_value == $past(stack_top_address) + 10'h001) else $error("bad return pc");
    a_ret_skip: assert property (acc && ((op_code == `TMX_OP_RET_C && !carry_flag) ||
        (op_code == `TMX_OP_RET_NC && carry_flag) || (op_code == `TMX_OP_RET_Z && !zero_flag) ||
        (op_code == `TMX_OP_RET_NZ && zero_flag)) |=> pc_value == $past(pc_value) + 10'h001)
        else $error("false return moved pc");
    a_reti_target: assert property (acc && (op_code == `TMX_OP_RETI_EN ||
        op_code == `TMX_OP_RETI_DIS) |=> pc_value == $past(stack_top_address) &&
        int_enable == $past(op_code[1])) else $error("bad interrupt return");
    a_irq_entry: assert property (!op_ready |-> int_enable ##1
        (pc_value == `TMX_INT_VECTOR && !int_enable && op_ready)) else $error("bad entry");

    c_out: cover property (acc && op_code == `TMX_OP_OUT && op_use_literal);
    c_reti: cover property (acc && op_code == `TMX_OP_RETI_EN);
    c_irq: cover property (!op_ready);
endmodule

bind tmx_exec tmx_exec_chk u_chk (.*);
`default_nettype wire

// ===== tmx_fabric.sv
// Fabric model that decodes one output port identifier.
// Assumes the core holds port_identifier and out_port as levels.
`timescale 1ns/100ps
`default_nettype none

module tmx_fabric #(
    parameter logic [7:0] MATCH_ID = 8'hff
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // Output port of the core
    input  wire logic [7:0] port_identifier,
    input  wire logic [7:0] out_port,
    // Decoded value
    output var  logic [7:0] capture_ff
);
    // Latch the value while the decoded identifier is shown
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            capture_ff <= 8'h00;
        end else if (port_identifier == MATCH_ID) begin
            capture_ff <= out_port;
        end
    end
endmodule
`default_nettype wire
